// file: mcp_checker.sv
// Port checker for the macrocell preload block
`timescale 1ns/10ps
module mcp_checker #(parameter N = 8, parameter IDW = 64, parameter RESET_CYCLES = 20) (
  input wire clk, input wire rst, input wire preload_enable, input wire dedicated_clk_in,
  input wire cfg_write, input wire id_write, input wire [IDW-1:0] id_data,
  input wire bulk_erase, input wire verify_req, input wire [N-1:0] out_level,
  input wire serial_state_oe, input wire [N-1:0] verify_arch_data,
  input wire verify_arch_valid, input wire [IDW-1:0] verify_id_data,
  input wire security_set, input wire cfg_refused
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Id write, then a verify request
  sequence s_idw;
    id_write && !bulk_erase ##1 verify_req && !id_write && !bulk_erase;
  endsequence
  // Normal mode with no register clock, erase or config
  sequence s_quiet;
    (!preload_enable && !dedicated_clk_in && !bulk_erase && !cfg_write)[*8];
  endsequence
  property p_refuse;
    cfg_write && security_set && !bulk_erase && !$past(bulk_erase) |=> cfg_refused;
  endproperty
  a_refuse: assert property (p_refuse) else $error("write kept");
  property p_hide;
    security_set && !bulk_erase && !$past(bulk_erase) |=> !verify_arch_valid && !verify_arch_data;
  endproperty
  a_hide: assert property (p_hide) else $error("array shown");
  property p_clr; $fell(security_set) |-> $past(bulk_erase) || $past(bulk_erase, 2); endproperty
  a_clr: assert property (p_clr) else $error("lock lost");
  property p_erase; bulk_erase |-> ##[1:2] !security_set; endproperty
  a_erase: assert property (p_erase) else $error("lock kept");
  property p_id; s_idw |=> verify_id_data == $past(id_data, 2); endproperty
  a_id: assert property (p_id) else $error("id wrong");
  property p_sdo; !preload_enable [*6] |-> !serial_state_oe; endproperty
  a_sdo: assert property (p_sdo) else $error("line pulled");
  property p_hold; s_quiet |-> $stable(out_level); endproperty
  a_hold: assert property (p_hold) else $error("state moved");
  // Freshly locked array stays hidden on the verify path
  property p_low;
    $rose(security_set) && !$past(bulk_erase) |-> !verify_arch_valid ##1 !verify_arch_valid;
  endproperty
  a_low: assert property (p_low) else $error("verify open");
endmodule // mcp_checker
bind mcp_macrocell_preload mcp_checker #(.N(N), .IDW(IDW), .RESET_CYCLES(RESET_CYCLES)) u_chk (.*);

// file: mcp_macrocell_preload.v
// Output macrocell registers with serial preload, security cell and id word
//
// Functional notes
// - Programmed security cell blocks array programming and array verify reads.
// - Security cell clears only during bulk erase, together with the array.
// - A 64-bit user identification word is held and reprogrammable.
// - Identification word never affects logic function or pin outputs; it only reaches verify_id_data.
// - Identification word reads back at any time, even when secured.
// - Bulk erase clears array, architecture cells, security and id word.
// - Preload writes any pattern and exposes state regardless of output enables.
// - After preload, registers advance from the preloaded values.
// - Preload enable switches registers to the serial shift path.
// - One bit per registered macrocell; non-registered cells are bypassed.
// - Chain advances one position per rising preload shift clock edge.
// - Data enters lowest registered cell and moves toward higher cells.
// - Registered mode uses dedicated clock and output enable inputs.
// - Shifting moves contents upward and out on serial state output.
// - Serial 0 is cleared, 1 is set; pins show states inverted.
// - Power-up reset clears all registers within bounded time.
`timescale 1ns/10ps
`include "mcp_regs.vh"
module mcp_macrocell_preload #(
  parameter N = `MCP_NUM_CELLS,
  parameter IDW = `MCP_ID_WIDTH,
  parameter RESET_CYCLES = `MCP_RESET_CYCLES
) (
  input wire clk,
  input wire rst,
  input wire preload_enable,
  input wire serial_preload_in,
  input wire preload_shift_clock,
  input wire dedicated_clk_in,
  input wire dedicated_oe_in,
  input wire [N-1:0] next_state,
  input wire [N-1:0] cell_registered,
  input wire [1:0] arch_mode,
  input wire cfg_write,
  input wire [N-1:0] cfg_reg_sel,
  input wire [1:0] cfg_mode,
  input wire cfg_set_security,
  input wire id_write,
  input wire [IDW-1:0] id_data,
  input wire bulk_erase,
  input wire verify_req,
  output reg [N-1:0] out_level,
  output reg [N-1:0] out_enable,
  output reg serial_state_out,
  output reg serial_state_oe,
  output reg [N-1:0] verify_arch_data,
  output reg verify_arch_valid,
  output reg [IDW-1:0] verify_id_data,
  output reg security_set,
  output reg reset_done,
  output reg cfg_refused
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  wire [4:0] sync_w;
  mcp_sync #(
    .WIDTH(5)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in({dedicated_oe_in, preload_enable, serial_preload_in, preload_shift_clock,
      dedicated_clk_in}),
    .sync_out(sync_w)
  );
  wire oe_s = sync_w[4];
  wire pre_en_s = sync_w[3];
  wire serial_preload_in_s = sync_w[2];
  wire preload_shift_clock_s = sync_w[1];
  wire gclk_s = sync_w[0];

  reg preload_shift_clock_prev_q;
  reg gclk_prev_q;
  reg [N-1:0] state_q;
  reg [N-1:0] arch_q;
  reg [1:0] mode_q;
  reg secure_q;
  reg [IDW-1:0] id_q;
  reg [31:0] por_cnt_q;

  // Edge detection on synchronised clocks
  wire preload_shift_clock_rise = preload_shift_clock_s & ~preload_shift_clock_prev_q;
  wire gclk_rise = gclk_s & ~gclk_prev_q;
  wire reg_mode = (mode_q == `MCP_MODE_REG);
  // Registered cells only exist in the registered architecture mode
  wire [N-1:0] is_reg = reg_mode ? arch_q : {N{1'b0}};

  // ----------------------------------------
  // Preload chain next values
  // ----------------------------------------
  // Each registered cell takes the nearest registered cell below it; the lowest takes the serial input
  reg [N-1:0] shift_d;
  reg carry;
  reg top_bit;
  integer i;
  always @*
  begin
    carry = serial_preload_in_s;
    top_bit = serial_preload_in_s;
    shift_d = state_q;
    for (i = 0; i < N; i = i + 1)
    begin
      if (is_reg[i])
      begin
        shift_d[i] = carry;
        carry = state_q[i];
        top_bit = state_q[i];
      end
    end
  end

  // ----------------------------------------
  // Power-up reset interval
  // ----------------------------------------
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      por_cnt_q <= 32'h00000000;
      reset_done <= 1'b0;
    end
    else if (!reset_done)
    begin
      por_cnt_q <= por_cnt_q + 32'h00000001;
      // Registers are held at reset and preload is ignored until this is set
      reset_done <= (por_cnt_q >= RESET_CYCLES - 1);
    end
  end

  // ----------------------------------------
  // Macrocell registers
  // ----------------------------------------
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= `MCP_REG_RESET;
      preload_shift_clock_prev_q <= 1'b0;
      gclk_prev_q <= 1'b0;
    end
    else
    begin
      preload_shift_clock_prev_q <= preload_shift_clock_s;
      gclk_prev_q <= gclk_s;
      if (!reset_done)
        state_q <= `MCP_REG_RESET;
      else if (pre_en_s)
      begin
        if (preload_shift_clock_rise)
          state_q <= shift_d;
      end
      // Normal load from array continues from preloaded state
      else if (gclk_rise)
        state_q <= (state_q & ~is_reg) | (next_state & is_reg);
    end
  end

  // ----------------------------------------
  // Configuration cells
  // ----------------------------------------
  // Id word is kept away from the pin output logic; it only reaches verify_id_data
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      arch_q <= {N{1'b0}};
      mode_q <= `MCP_MODE_SMALL;
      secure_q <= 1'b0;
      id_q <= `MCP_ID_RESET;
      cfg_refused <= 1'b0;
    end
    else
    begin
      cfg_refused <= 1'b0;
      if (bulk_erase)
      begin
        arch_q <= {N{1'b0}};
        mode_q <= `MCP_MODE_SMALL;
        secure_q <= 1'b0;
        id_q <= `MCP_ID_RESET;
      end
      else
      begin
        if (cfg_write)
        begin
          if (secure_q)
            cfg_refused <= 1'b1;
          else
          begin
            arch_q <= cfg_reg_sel;
            mode_q <= cfg_mode;
          end
        end
        if (cfg_set_security)
          secure_q <= 1'b1;
        if (id_write)
          id_q <= id_data;
      end
    end
  end

  // ----------------------------------------
  // Verify and pin outputs
  // ----------------------------------------
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      out_level <= {N{1'b1}};
      out_enable <= {N{1'b0}};
      serial_state_out <= 1'b0;
      serial_state_oe <= 1'b0;
      verify_arch_data <= {N{1'b0}};
      verify_arch_valid <= 1'b0;
      verify_id_data <= {IDW{1'b0}};
      security_set <= 1'b0;
    end
    else
    begin
      // Pins show registers inverted regardless of polarity
      out_level <= ~state_q;
      out_enable <= is_reg & {N{~oe_s & reg_mode}};
      // Open drain: drive low only when serial bit is 0
      serial_state_out <= 1'b0;
      serial_state_oe <= pre_en_s & ~top_bit;
      security_set <= secure_q;
      verify_arch_valid <= verify_req & ~secure_q;
      verify_arch_data <= (verify_req & ~secure_q) ? arch_q : {N{1'b0}};
      verify_id_data <= verify_req ? id_q : verify_id_data;
    end
  end
endmodule // mcp_macrocell_preload

// file: mcp_macrocell_preload_test.sv
// Bench for the macrocell preload block
`timescale 1ns/10ps
`include "mcp_regs.vh"
module mcp_macrocell_preload_test;
  logic clk = 0, rst = 1, dck = 0, oe_n = 0, cw = 0, cs = 0, iw = 0, er = 0, vr = 0;
  logic [7:0] ns = 0, sel = 0, ol, oen, vad, m, p, prev;
  logic [63:0] idd = 0, vid, idv;
  logic [1:0] md = 0;
  logic ssoe, vav, secs, rdy, rfs, pe, sin, sck, sso;
  int failures = 0, total_checks = 0, cyc = 0, k, w;
  // Open-drain state line with pull-up
  mcp_tester tst (.clk(clk), .line(!ssoe), .preload_enable(pe), .serial_preload_in(sin),
    .preload_shift_clock(sck));
  mcp_macrocell_preload #(.RESET_CYCLES(20)) DUT (.clk(clk), .rst(rst), .preload_enable(pe),
    .serial_preload_in(sin), .preload_shift_clock(sck), .dedicated_clk_in(dck),
    .dedicated_oe_in(oe_n), .next_state(ns), .cell_registered(8'h00), .arch_mode(2'h0),
    .cfg_write(cw), .cfg_reg_sel(sel), .cfg_mode(md), .cfg_set_security(cs), .id_write(iw),
    .id_data(idd), .bulk_erase(er), .verify_req(vr), .out_level(ol), .out_enable(oen),
    .serial_state_out(sso), .serial_state_oe(ssoe), .verify_arch_data(vad),
    .verify_arch_valid(vav), .verify_id_data(vid), .security_set(secs), .reset_done(rdy),
    .cfg_refused(rfs));
  always #2 clk = ~clk;
  // Watchdog on the whole run
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      failures++;
      print_verdict;
    end
  end
  task print_verdict;
    if (failures == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Chain order is ascending cell index over registered cells only
  function automatic logic [7:0] put(input logic [7:0] c, input logic [7:0] s);
    int j = 0;
    put = 8'h00;
    for (int i = 0; i < 8; i++)
      if (s[i])
        put[i] = c[j++];
  endfunction
  function automatic logic [7:0] get(input logic [7:0] v, input logic [7:0] s);
    int j = 0;
    get = 8'h00;
    for (int i = 0; i < 8; i++)
      if (s[i])
        get[j++] = v[i];
  endfunction
  // Register clock pulse, long enough for the synchroniser
  task tick;
    dck <= 1'b1;
    repeat (4) @(posedge clk);
    dck <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  initial
  begin
    w = $urandom(32'h42c1be03);
    // Reset values only show after the first edge in reset
    @(posedge clk);
    @(posedge clk);
    chk(ol, 8'hff);
    rst <= 0;
    for (w = 0; w < 40 && rdy !== 1'b1; w++) @(posedge clk);
    // Interval of 20 cycles, plus one edge before the flag is seen
    chk(w, 21);
    chk(ol, 8'hff);
    m = 8'($urandom) | 8'h81;
    k = $countones(m);
    sel <= m;
    md <= `MCP_MODE_REG;
    er <= 1;
    @(posedge clk);
    er <= 0;
    cw <= 1;
    @(posedge clk);
    cw <= 0;
    prev = 0;
    for (int it = 0; it < 3; it++)
    begin
      p = it ? 8'($urandom) : 8'hff;
      tst.frame(p, k);
      chk(tst.rd, prev);
      chk(sso, 1'b0);
      tick;
      // Bypassed cells must keep their cleared state as well
      chk(~ol & 8'hff, put(p, m));
      tst.preload_enable <= 0;
      ns <= 8'($urandom);
      tick;
      chk(~ol & 8'hff, ns & m);
      chk(oen & m, m);
      prev = get(ns, m);
    end
    idv = {$urandom, $urandom};
    idd <= idv;
    iw <= 1;
    cs <= 1;
    @(posedge clk);
    iw <= 0;
    cs <= 0;
    vr <= 1;
    repeat (3) @(posedge clk);
    chk(vid, idv);
    chk({secs, vav, vad}, 10'h200);
    cw <= 1;
    @(posedge clk);
    cw <= 0;
    @(posedge clk);
    chk(rfs, 1'b1);
    er <= 1;
    @(posedge clk);
    er <= 0;
    repeat (3) @(posedge clk);
    chk(vid, 64'h0);
    chk({secs, vav, vad}, 10'h100);
    cw <= 1;
    @(posedge clk);
    cw <= 0;
    repeat (3) @(posedge clk);
    chk(vad, m);
    print_verdict;
  end
endmodule // mcp_macrocell_preload_test

// file: mcp_regs.vh
// Constants for the macrocell preload and configuration cell block
`ifndef MCP_REGS_VH
`define MCP_REGS_VH
// Number of output macrocells
`define MCP_NUM_CELLS 8
// Identification word width
`define MCP_ID_WIDTH 64
// Architecture mode codes
`define MCP_MODE_SMALL 2'h0
`define MCP_MODE_REG 2'h1
`define MCP_MODE_MEDIUM 2'h2
// Reset values
`define MCP_ID_RESET 64'h0000000000000000
`define MCP_REG_RESET 8'h00
// Power-up reset time in microseconds and clock rate in MHz
`define MCP_RESET_TIME_US 45
`define MCP_CLK_MHZ 250
`define MCP_RESET_CYCLES (`MCP_RESET_TIME_US * `MCP_CLK_MHZ)
`endif

// file: mcp_sync.v
// Two-flop synchroniser for inputs arriving from outside the clock domain
`timescale 1ns/10ps
module mcp_sync #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;

  // First stage only feeds the second stage
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // mcp_sync

// file: mcp_tester.sv
// Tester model driving the preload pins
`timescale 1ns/10ps
module mcp_tester (
  input wire clk,
  input wire line,
  output logic preload_enable = 1'b0,
  output logic serial_preload_in = 1'b0,
  output logic preload_shift_clock = 1'b0
);
  logic [7:0] rd = 8'h00;
  // One frame, first bit p[k-1]; shift clock rests low outside frames
  task frame(input logic [7:0] p, input int k);
    rd <= 8'h00;
    preload_enable <= 1'b1;
    repeat (16) @(posedge clk);
    for (int i = k - 1; i >= 0; i--)
    begin
      serial_preload_in <= p[i];
      repeat (15) @(posedge clk);
      rd <= {rd[6:0], line};
      preload_shift_clock <= 1'b1;
      repeat (16) @(posedge clk);
      preload_shift_clock <= 1'b0;
    end
    repeat (16) @(posedge clk);
  endtask
endmodule // mcp_tester
